// >>> logic/clock_status_pkg.sv
package clock_status_pkg;

  // Register addresses on the internal I/O bus
  localparam logic [7:0] global_control_status_addr = 8'h00;
  localparam logic [7:0] rom_config_id_addr = 8'h2c;
  localparam logic [7:0] ram_config_id_addr = 8'h2d;
  localparam logic [7:0] cpu_type_id_addr = 8'h2e;
  localparam logic [7:0] silicon_revision_id_addr = 8'h2f;
  localparam logic [7:0] unmapped_read_value = 8'h00;

  // Field positions of the global control/status register
  localparam int cause_msb = 7;
  localparam int cause_lsb = 6;
  localparam int force_bit = 5;
  localparam int select_msb = 4;
  localparam int select_lsb = 2;
  localparam int priority_msb = 1;
  localparam int priority_lsb = 0;

  // Reset-cause codes
  localparam logic [1:0] cause_none = 2'h0;
  localparam logic [1:0] cause_watchdog = 2'h1;
  localparam logic [1:0] cause_reset = 2'h3;

  // Values after reset
  localparam logic [2:0] select_reset = 3'h0;
  localparam logic [1:0] priority_reset = 2'h0;
  localparam logic [3:0] divide_reset = 4'h8;
  localparam logic [4:0] term_reset = 5'h07;
  localparam logic [7:0] lfsr_seed = 8'h5a;

  // Identifier codes; the values are arbitrary
  localparam logic [4:0] rom_id_code = 5'h1a;
  localparam logic [4:0] ram_id_code = 5'h1b;
  localparam logic [4:0] cpu_id_code = 5'h1c;
  localparam logic [4:0] revision_id_code = 5'h1d;

  // Baud tick from the 32.768 kHz clock: fractional accumulator
  localparam logic [15:0] baud_step = 16'h0960;
  localparam int baud_carry_bit = 15;

  typedef enum logic [1:0] {
    cs_none = 2'b00,
    cs_short = 2'b01,
    cs_self_timed = 2'b11
  } cs_mode_type;

  typedef enum logic [1:0] {
    spread_off = 2'b00,
    spread_normal = 2'b01,
    spread_strong = 2'b11
  } spread_mode_type;

  typedef enum logic {
    sp_even = 1'b0,
    sp_owed = 1'b1
  } spread_state_type;

  // Clock plan selected by the clock select field
  typedef struct packed {
    logic [3:0] cpu_div;
    logic [3:0] periph_div;
    logic slow;
    logic osc_on;
    cs_mode_type cs;
  } clk_plan_type;

  function automatic clk_plan_type decode_select(input logic [2:0] sel);
    clk_plan_type p;
    p = '{cpu_div: 4'h8, periph_div: 4'h8, slow: 1'b0, osc_on: 1'b1, cs: cs_short};
    case (sel)
      3'h0: p = '{4'h8, 4'h8, 1'b0, 1'b1, cs_short};
      3'h1: p = '{4'h8, 4'h1, 1'b0, 1'b1, cs_short};
      3'h2: p = '{4'h1, 4'h1, 1'b0, 1'b1, cs_none};
      3'h3: p = '{4'h2, 4'h2, 1'b0, 1'b1, cs_none};
      3'h4: p = '{4'h1, 4'h1, 1'b1, 1'b1, cs_self_timed};
      3'h5: p = '{4'h1, 4'h1, 1'b1, 1'b0, cs_self_timed};
      3'h6: p = '{4'h4, 4'h4, 1'b0, 1'b1, cs_short};
      3'h7: p = '{4'h6, 4'h6, 1'b0, 1'b1, cs_short};
      default: p = '{4'h8, 4'h8, 1'b0, 1'b1, cs_short};
    endcase
    return p;
  endfunction

endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int width = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] level_out
);
  import clock_status_pkg::*;

  // Three stages per bit; the level moves once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, stable_reg;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
          end
        end
      end
      assign level_out[i] = stable_reg;
    end
  endgenerate

endmodule // pin_sync

// >>> logic/clk_divider.sv
`timescale 1ns/1ps
module clk_divider (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [3:0] divide_in,
  input wire logic slow,
  input wire logic slow_tick,
  input wire logic spread_on,
  output logic tick,
  output logic near_end
);
  import clock_status_pkg::*;

  logic [4:0] cnt_reg;
  logic [4:0] term_reg;
  logic [3:0] div_reg;
  logic [4:0] base_term;
  spread_state_type state_reg;

  // Period end: own count, or the 32 kHz edge in slow modes
  assign base_term = {1'b0, div_reg} - 5'h01;
  assign tick = slow ? slow_tick : (cnt_reg == term_reg);
  // Last two undivided clocks of the period
  assign near_end = !slow && ((cnt_reg + 5'h01) >= term_reg);

  // Period counter; a stretched period is paid back by a shrunk one unless a restart clears the owed state first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 5'h00;
      term_reg <= term_reset;
      div_reg <= divide_reset;
      state_reg <= sp_even;
    end else if (restart) begin
      cnt_reg <= 5'h00;
      div_reg <= divide_in;
      term_reg <= {1'b0, divide_in} - 5'h01;
      state_reg <= sp_even;
    end else if (!slow) begin
      if (tick) begin
        cnt_reg <= 5'h00;
        case (state_reg)
          sp_owed: begin
            term_reg <= base_term - 5'h01;
            state_reg <= sp_even;
          end
          sp_even: begin
            if (spread_on && div_reg >= 4'h2) begin
              term_reg <= base_term + 5'h01;
              state_reg <= sp_owed;
            end else begin
              term_reg <= base_term;
            end
          end
          default: begin
            term_reg <= base_term;
            state_reg <= sp_even;
          end
        endcase
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

endmodule // clk_divider

// >>> logic/global_clock_status_and_id.sv
`timescale 1ns/1ps
module global_clock_status_and_id (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [1:0] boot_mode_pins,
  input wire logic boot_fetch_ignore,
  input wire logic slow_clk_pin,
  input wire logic watchdog_timeout,
  input wire logic ps_short_cs,
  input wire clock_status_pkg::spread_mode_type spread_mode,
  input wire logic mem_cs_req,
  output logic mem_chip_sel,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic main_osc_enable,
  output clock_status_pkg::cs_mode_type cs_mode,
  output logic periodic_force,
  output logic [1:0] periodic_priority,
  output logic baud_tick
);
  import clock_status_pkg::*;

  logic [2:0] select_reg;
  logic [2:0] active_select_reg;
  logic [1:0] priority_reg;
  logic [1:0] cause_reg;
  logic [7:0] rdata_reg;
  logic force_reg;
  logic [7:0] lfsr_reg;
  logic [15:0] baud_acc_reg;
  logic baud_reg;
  logic slow_level_reg;
  logic cpu_en_reg, periph_en_reg, osc_reg, mem_cs_reg;
  cs_mode_type cs_mode_reg;

  logic [3:0] synced;
  logic [1:0] boot_pins_s;
  logic boot_ignore_s, slow_level_s, slow_tick;
  logic wr_gcs, rd_gcs, pending, switch_now, spread_on;
  logic cpu_tick, periph_tick, cpu_near_end;
  logic [2:0] id_top;
  logic [15:0] baud_sum;
  cs_mode_type cs_mode_next;
  clk_plan_type plan_active, plan_new;

  // Pins from outside the clock domain
  pin_sync #(.width(4)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({slow_clk_pin, boot_fetch_ignore, boot_mode_pins}),
    .level_out(synced)
  );
  assign boot_pins_s = synced[1:0];
  assign boot_ignore_s = synced[2];
  assign slow_level_s = synced[3];

  // Rising edge of the 32.768 kHz clock as an enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slow_level_reg <= 1'b0;
    end else begin
      slow_level_reg <= slow_level_s;
    end
  end
  assign slow_tick = slow_level_s && !slow_level_reg;

  // Bus decode
  assign wr_gcs = io_wr && (io_addr == global_control_status_addr);
  assign rd_gcs = io_rd && (io_addr == global_control_status_addr);

  // Software-written control fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      select_reg <= select_reset;
      priority_reg <= priority_reset;
    end else if (wr_gcs) begin
      select_reg <= io_wdata[select_msb:select_lsb];
      priority_reg <= io_wdata[priority_msb:priority_lsb];
    end
  end

  // Forced periodic interrupt request, one-cycle pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      force_reg <= 1'b0;
    end else begin
      force_reg <= wr_gcs && io_wdata[force_bit];
    end
  end

  // Reset cause; a watchdog event wins over a clearing read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_reg <= cause_reset;
    end else if (watchdog_timeout) begin
      cause_reg <= cause_watchdog;
    end else if (rd_gcs) begin
      cause_reg <= cause_none;
    end
  end

  // Identification upper bits shared by all four registers
  assign id_top = {boot_ignore_s, boot_pins_s};

  // Read data, one cycle after the read strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= unmapped_read_value;
    end else if (io_rd) begin
      case (io_addr)
        global_control_status_addr: begin
          rdata_reg <= {cause_reg, 1'b0, select_reg, priority_reg};
        end
        rom_config_id_addr: rdata_reg <= {id_top, rom_id_code};
        ram_config_id_addr: rdata_reg <= {id_top, ram_id_code};
        cpu_type_id_addr: rdata_reg <= {id_top, cpu_id_code};
        silicon_revision_id_addr: rdata_reg <= {id_top, revision_id_code};
        default: rdata_reg <= unmapped_read_value;
      endcase
    end
  end
  // Identification addresses have no write path at all

  // Clock plans: active one and the one software asked for
  assign plan_active = decode_select(active_select_reg);
  assign plan_new = decode_select(select_reg);
  assign pending = select_reg != active_select_reg;
  // Switch only where both clocks end a period together
  assign switch_now = pending && cpu_tick && periph_tick;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_select_reg <= select_reset;
    end else if (switch_now) begin
      active_select_reg <= select_reg;
    end
  end

  // Pattern source for spreading, stepped once per CPU period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lfsr_reg <= lfsr_seed;
    end else if (cpu_tick) begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end

  // Strong adjusts every pair of periods, normal only on pattern bits
  always_comb begin
    case (spread_mode)
      spread_strong: spread_on = 1'b1;
      spread_normal: spread_on = lfsr_reg[0];
      default: spread_on = 1'b0;
    endcase
  end

  clk_divider u_cpu_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(switch_now),
    .divide_in(plan_new.cpu_div),
    .slow(plan_active.slow),
    .slow_tick(slow_tick),
    .spread_on(spread_on),
    .tick(cpu_tick),
    .near_end(cpu_near_end)
  );

  clk_divider u_periph_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(switch_now),
    .divide_in(plan_new.periph_div),
    .slow(plan_active.slow),
    .slow_tick(slow_tick),
    .spread_on(spread_on),
    .tick(periph_tick),
    .near_end()
  );

  // Power-save chip select mode
  always_comb begin
    if (ps_short_cs) begin
      cs_mode_next = plan_active.cs;
    end else begin
      cs_mode_next = cs_none;
    end
  end

  // Clock enables, oscillator control and chip select outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_en_reg <= 1'b0;
      periph_en_reg <= 1'b0;
      osc_reg <= 1'b1;
      cs_mode_reg <= cs_none;
      mem_cs_reg <= 1'b0;
    end else begin
      cpu_en_reg <= cpu_tick;
      periph_en_reg <= periph_tick;
      osc_reg <= plan_active.osc_on;
      cs_mode_reg <= cs_mode_next;
      if (cs_mode_next == cs_short) begin
        mem_cs_reg <= mem_cs_req && cpu_near_end;
      end else begin
        mem_cs_reg <= mem_cs_req;
      end
    end
  end

  // 2400 baud from the 32.768 kHz edge by fractional accumulation
  assign baud_sum = baud_acc_reg + baud_step;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      baud_acc_reg <= 16'h0000;
      baud_reg <= 1'b0;
    end else begin
      baud_reg <= slow_tick && baud_sum[baud_carry_bit];
      if (slow_tick) begin
        baud_acc_reg <= {1'b0, baud_sum[baud_carry_bit-1:0]};
      end
    end
  end

  assign io_rdata = rdata_reg;
  assign mem_chip_sel = mem_cs_reg;
  assign cpu_clk_en = cpu_en_reg;
  assign periph_clk_en = periph_en_reg;
  assign main_osc_enable = osc_reg;
  assign cs_mode = cs_mode_reg;
  assign periodic_force = force_reg;
  assign periodic_priority = priority_reg;
  assign baud_tick = baud_reg;

endmodule // global_clock_status_and_id

// >>> tb/global_clock_status_and_id_assertions.sv
`timescale 1ns/1ps
module global_clock_status_and_id_assertions
  import clock_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic watchdog_timeout,
  input wire logic mem_cs_req,
  input wire logic mem_chip_sel,
  input wire clock_status_pkg::cs_mode_type cs_mode,
  input wire logic periodic_force,
  input wire logic [1:0] periodic_priority
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Status register accesses
  sequence rd_status;
    io_rd && io_addr == global_control_status_addr;
  endsequence
  sequence wr_status;
    io_wr && io_addr == global_control_status_addr;
  endsequence
  sequence clean_reread;
    rd_status ##0 !watchdog_timeout ##1 (!watchdog_timeout && !io_rd)[*3] ##1 rd_status;
  endsequence

  chk_cause_legal: assert property (rd_status |=> io_rdata[7:6] != 2'h2)
    else $error("cause field shows 10");
  chk_clear_on_read: assert property (clean_reread |=> io_rdata[7:6] == cause_none)
    else $error("cause not cleared by read");
  chk_watchdog_cause: assert property (watchdog_timeout ##2 rd_status |=> io_rdata[7:6] == cause_watchdog)
    else $error("watchdog cause missing");
  chk_force_reads_zero: assert property (rd_status |=> !io_rdata[force_bit])
    else $error("force bit reads one");
  chk_force_pulse: assert property (wr_status ##0 io_wdata[force_bit] |=> periodic_force ##1 !periodic_force)
    else $error("force pulse wrong");
  chk_no_force: assert property (!(io_wr && io_wdata[force_bit]) |=> !periodic_force)
    else $error("force without write");
  chk_priority_set: assert property (wr_status |=> periodic_priority == $past(io_wdata[1:0]))
    else $error("priority not taken");
  chk_cpu_id: assert property (io_rd && io_addr == cpu_type_id_addr |=> io_rdata[4:0] == cpu_id_code)
    else $error("cpu identifier wrong");
  chk_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without read");
  chk_cs_gated: assert property (!mem_cs_req |=> !mem_chip_sel)
    else $error("chip select without request");
  chk_short_two: assert property ((cs_mode == cs_short && mem_chip_sel)[*3] |-> 1'b0)
    else $error("short chip select over two cycles");
endmodule // global_clock_status_and_id_assertions

// >>> tb/global_clock_status_and_id_bench.sv
`timescale 1ns/1ps
module global_clock_status_and_id_bench;
  import clock_status_pkg::*;
  logic ref_clk = 1'h0, rst = 1'h1, io_wr = 1'h0, io_rd = 1'h0, slow_clk_pin = 1'h0;
  logic boot_fetch_ignore = 1'h1, watchdog_timeout = 1'h0, ps_short_cs = 1'h1;
  logic mem_cs_req = 1'h0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata;
  logic [1:0] boot_mode_pins = 2'h2, periodic_priority;
  spread_mode_type spread_mode = spread_off;
  logic mem_chip_sel, cpu_clk_en, periph_clk_en, main_osc_enable, periodic_force, baud_tick;
  cs_mode_type cs_mode;
  int n_errors = 0, samples_checked = 0;

  global_clock_status_and_id dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .boot_mode_pins(boot_mode_pins), .boot_fetch_ignore(boot_fetch_ignore),
    .slow_clk_pin(slow_clk_pin), .watchdog_timeout(watchdog_timeout),
    .ps_short_cs(ps_short_cs), .spread_mode(spread_mode), .mem_cs_req(mem_cs_req),
    .mem_chip_sel(mem_chip_sel), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .main_osc_enable(main_osc_enable), .cs_mode(cs_mode), .periodic_force(periodic_force),
    .periodic_priority(periodic_priority), .baud_tick(baud_tick));

  // Main clock and free-running 32 kHz stand-in (80 cycles)
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    forever #200 slow_clk_pin = ~slow_clk_pin;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    io_wr <= 1'h1;
    io_addr <= a;
    io_wdata <= v;
    @(posedge ref_clk);
    io_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    io_rd <= 1'h1;
    io_addr <= a;
    @(posedge ref_clk);
    io_rd <= 1'h0;
    @(posedge ref_clk);
    #1;
    v = io_rdata;
  endtask

  // Cycles spanned by k periods of a pulse output, bounded
  task automatic span(input int which, input int k, output int n);
    int j;
    logic s;
    n = 0;
    for (j = 0; j <= k; j++) begin
      if (j == 1) n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
        s = which == 0 ? cpu_clk_en : which == 1 ? periph_clk_en : baud_tick;
      end while (s !== 1'h1 && n < 3000);
      if (n >= 3000) begin
        n_errors++;
        test_done();
      end
    end
  endtask

  task automatic t_cause();
    logic [7:0] d;
    rd(global_control_status_addr, d);
    check("cause_reset", d, {cause_reset, 1'h0, select_reset, priority_reset});
    rd(global_control_status_addr, d);
    check("cause_clear", d, {cause_none, 6'h00});
  endtask

  task automatic t_ids();
    logic [7:0] d;
    logic [4:0] codes[4] = '{rom_id_code, ram_id_code, cpu_id_code, revision_id_code};
    for (int i = 0; i < 4; i++) begin
      rd(rom_config_id_addr + 8'(i), d);
      check("id", d, {1'h1, 2'h2, codes[i]});
    end
    wr(cpu_type_id_addr, 8'hff);
    rd(cpu_type_id_addr, d);
    check("id_write", d, {1'h1, 2'h2, cpu_id_code});
    boot_mode_pins <= 2'h1;
    boot_fetch_ignore <= 1'h0;
    repeat (6) @(posedge ref_clk);
    rd(silicon_revision_id_addr, d);
    check("id_pins", d, {1'h0, 2'h1, revision_id_code});
    rd(8'h55, d);
    check("unmapped", d, unmapped_read_value);
  endtask

  task automatic t_control();
    logic [7:0] d;
    for (int p = 0; p < 4; p++) begin
      wr(global_control_status_addr, {2'h3, p[0], 3'h0, p[1:0]});
      #1;
      check("force", periodic_force, 16'(p[0]));
      check("prio", periodic_priority, 16'(p[1:0]));
      rd(global_control_status_addr, d);
      check("ctl_read", d, {2'h0, 1'h0, 3'h0, p[1:0]});
    end
    @(posedge ref_clk);
    watchdog_timeout <= 1'h1;
    @(posedge ref_clk);
    watchdog_timeout <= 1'h0;
    rd(global_control_status_addr, d);
    check("cause_wdog", d, {cause_watchdog, 1'h0, 3'h0, 2'h3});
  endtask

  task automatic t_clocks();
    int n;
    int cdiv[8] = '{8, 8, 1, 2, 80, 80, 4, 6};
    int pdiv[8] = '{8, 1, 1, 2, 80, 80, 4, 6};
    cs_mode_type cm[8] = '{cs_short, cs_short, cs_none, cs_none, cs_self_timed,
      cs_self_timed, cs_short, cs_short};
    for (int c = 0; c < 8; c++) begin
      wr(global_control_status_addr, {3'h0, c[2:0], 2'h0});
      repeat (200) @(posedge ref_clk);
      #1;
      check("osc_on", main_osc_enable, 16'(c != 5));
      check("cs_mode", 16'(cs_mode), 16'(cm[c]));
      span(0, 1, n);
      check("cpu_period", 16'(n), 16'(cdiv[c]));
      span(1, 1, n);
      check("periph_period", 16'(n), 16'(pdiv[c]));
    end
    // Strong spreading on divide by 6: uneven periods, pairs keep 12
    spread_mode <= spread_strong;
    span(0, 1, n);
    span(0, 1, n);
    check("spread_uneven", 16'(n != 6), 16'h1);
    span(0, 2, n);
    check("spread_pair", 16'(n), 16'd12);
    spread_mode <= spread_normal;
    repeat (50) @(posedge ref_clk);
    spread_mode <= spread_off;
  endtask

  task automatic t_short_cs();
    int k;
    wr(global_control_status_addr, 8'h00);
    repeat (100) @(posedge ref_clk);
    for (int m = 0; m < 2; m++) begin
      mem_cs_req <= 1'h1;
      repeat (4) @(posedge ref_clk);
      k = 0;
      repeat (80) begin
        @(posedge ref_clk);
        #1;
        if (mem_chip_sel === 1'h1) k++;
      end
      check("cs_cycles", 16'(k), m == 0 ? 16'd20 : 16'd80);
      ps_short_cs <= 1'h0;
    end
    mem_cs_req <= 1'h0;
    ps_short_cs <= 1'h1;
  endtask

  task automatic t_baud();
    int n;
    span(2, 1, n);
    check("baud_gap", 16'(n >= 1038 && n <= 1122), 16'h1);
  endtask

  initial begin
    do_reset();
    t_cause();
    t_ids();
    t_control();
    t_clocks();
    t_short_cs();
    t_baud();
    do_reset();
    t_cause();
    test_done();
  end
endmodule // global_clock_status_and_id_bench

bind global_clock_status_and_id global_clock_status_and_id_assertions chk (
  .ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .watchdog_timeout(watchdog_timeout),
  .mem_cs_req(mem_cs_req), .mem_chip_sel(mem_chip_sel), .cs_mode(cs_mode),
  .periodic_force(periodic_force), .periodic_priority(periodic_priority));
